// ---- src/olsi_regs.svh ----
`ifndef OLSI_REGS_SVH
`define OLSI_REGS_SVH

// Register byte offsets on the control bus.
`define OLSI_CTRL_OFF       8'h00
`define OLSI_STATUS_OFF     8'h04
`define OLSI_IRQ_STAT_OFF   8'h08
`define OLSI_IRQ_EN_OFF     8'h0c
`define OLSI_IRQ_CLR_OFF    8'h10
`define OLSI_TEMP_TIME_OFF  8'h14

// Control register fields.
`define OLSI_CTRL_REARM     0

// Status register fields.
`define OLSI_ST_TX_EN       0
`define OLSI_ST_OPT_OK      1
`define OLSI_ST_CABLE_UP    2
`define OLSI_ST_TEMP_WARN   3
`define OLSI_ST_TEMP_HOT    4
`define OLSI_ST_LASER_WEAR  5
`define OLSI_ST_LASER_TRIP  6
`define OLSI_ST_INIT_DONE   7

// Event bits, common to interrupt status, enable and clear.
`define OLSI_EV_LASER_TRIP  0
`define OLSI_EV_TEMP_HOT    1
`define OLSI_EV_OPT_LOST    2
`define OLSI_EV_CABLE_LOST  3

// Reset values and bus answers.
`define OLSI_IRQ_EN_RST     4'h0
`define OLSI_RESP_OKAY      2'h0
`define OLSI_RESP_SLVERR    2'h2

// Timing, each figure in its own unit and as a cycle count.
`define OLSI_CLK_HZ         10000000
`define OLSI_BLINK_HALF_MS  250
`define OLSI_BLINK_CYC      (`OLSI_CLK_HZ / 1000 * `OLSI_BLINK_HALF_MS)
`define OLSI_STRETCH_MS     30
`define OLSI_STRETCH_CYC    (`OLSI_CLK_HZ / 1000 * `OLSI_STRETCH_MS)
`define OLSI_SEC_S          1
`define OLSI_SEC_CYC        (`OLSI_CLK_HZ * `OLSI_SEC_S)

`endif

// ---- src/olsi_pkg.sv ----
package olsi_pkg;

	typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_ORANGE, LED_RED} olsi_led_e;

	typedef enum logic {LAS_RUN, LAS_TRIP} olsi_laser_e;

	typedef enum logic [2:0] {
		REG_CTRL, REG_STATUS, REG_IRQ_STAT, REG_IRQ_EN, REG_IRQ_CLR, REG_TEMP_TIME, REG_NONE
	} olsi_reg_e;

endpackage

// ---- src/olsi_tick_gen.sv ----
`include "olsi_regs.svh"

module olsi_tick_gen
	import olsi_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = `OLSI_BLINK_CYC,
	parameter int unsigned SEC_CYCLES   = `OLSI_SEC_CYC
) (
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// Timing outputs.
	output logic      blinkPhase,
	output logic      secTick
);
	typedef struct packed {
		logic [23:0] blinkCnt;
		logic [23:0] secCnt;
		logic        blinkPhase;
		logic        secTick;
	} olsi_tick_s;

	olsi_tick_s tick_q;
	olsi_tick_s tick_d;

	always_comb begin
		tick_d = tick_q;
		tick_d.secTick = 1'b0;
		if (tick_q.blinkCnt == 24'(BLINK_CYCLES - 1)) begin
			tick_d.blinkCnt = 24'h0;
			tick_d.blinkPhase = ~tick_q.blinkPhase;
		end else begin
			tick_d.blinkCnt = tick_q.blinkCnt + 24'h1;
		end
		if (tick_q.secCnt == 24'(SEC_CYCLES - 1)) begin
			tick_d.secCnt = 24'h0;
			tick_d.secTick = 1'b1;
		end else begin
			tick_d.secCnt = tick_q.secCnt + 24'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tick_q <= '0;
		end else begin
			tick_q <= tick_d;
		end
	end

	assign blinkPhase = tick_q.blinkPhase;
	assign secTick    = tick_q.secTick;
endmodule

// ---- src/olsi_act_stretch.sv ----
`include "olsi_regs.svh"

module olsi_act_stretch
	import olsi_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = `OLSI_STRETCH_CYC
) (
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// Traffic pulse in, stretched level out.
	input  wire logic activity,
	output logic      active
);
	typedef struct packed {
		logic [23:0] holdCnt;
		logic        active;
	} olsi_act_s;

	olsi_act_s act_q;
	olsi_act_s act_d;

	// A single frame lasts microseconds; holding it keeps it visible to the eye.
	always_comb begin
		act_d = act_q;
		if (activity) begin
			act_d.holdCnt = 24'(HOLD_CYCLES);
		end else if (act_q.holdCnt != 24'h0) begin
			act_d.holdCnt = act_q.holdCnt - 24'h1;
		end
		act_d.active = (act_d.holdCnt != 24'h0);
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			act_q <= '0;
		end else begin
			act_q <= act_d;
		end
	end

	assign active = act_q.active;
endmodule

// ---- src/olsi_indicator_top.sv ----
// Contract
// - Temperature lamp dark while temperature is inside the working range.
// - Up to 5 degC outside range: temperature lamp steady orange, transmission stays on.
// - Over 5 degC outside: lamp steady red, time counted, transmission continues.
// - Laser lamp dark while the laser diode has enough reserve.
// - Laser near end of life: lamp steady orange, transmission continues.
// - Laser overcurrent: transmitter switched off, laser lamp flashes orange.
// - Device error: power lamp steady red, function restricted.
// - Optical link lamp dark without optical connection; no data passes then.
// - Optical link lamp dark when local or partner transmitter is off.
// - Optical link lamp steady green when link is up without traffic.
// - Optical link lamp orange while data crosses the optical path.
// - Link error lamp orange on partner cable loss or poor partner quality.
// - Link error lamp red on local cable loss or poor quality, else dark.
// - Cable lamp dark without a wired link.
// - Cable lamp steady green with good wired link and no traffic.
// - Cable lamp orange while wired link carries data.
// - Power lamp flashes green in init, steady green when ready, flashes red on warning.
`include "olsi_regs.svh"

module olsi_indicator_top
	import olsi_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES   = `OLSI_BLINK_CYC,
	parameter int unsigned SEC_CYCLES     = `OLSI_SEC_CYC,
	parameter int unsigned STRETCH_CYCLES = `OLSI_STRETCH_CYC
) (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Temperature monitor.
	input  wire logic        tempOutOfRange,
	input  wire logic        tempBeyondMargin,
	// Laser monitor.
	input  wire logic        laserWearOut,
	input  wire logic        laserOverCurrent,
	// Optical path.
	input  wire logic        optLinkUp,
	input  wire logic        partnerTxOff,
	input  wire logic        optTraffic,
	input  wire logic        localQualityLow,
	input  wire logic        remoteQualityLow,
	input  wire logic        remoteCableDown,
	// Wired port.
	input  wire logic        cableLinkUp,
	input  wire logic        cableTraffic,
	// Device state.
	input  wire logic        initDone,
	input  wire logic        deviceError,
	// Transmission control.
	output logic             txEnable,
	output logic             dataEnable,
	// Panel lamps, orange is red and green together.
	output logic             temperatureIndicatorRed,
	output logic             temperatureIndicatorGreen,
	output logic             laserIndicatorRed,
	output logic             laserIndicatorGreen,
	output logic             opticalLinkIndicatorRed,
	output logic             opticalLinkIndicatorGreen,
	output logic             linkErrorIndicatorRed,
	output logic             linkErrorIndicatorGreen,
	output logic             cableIndicatorRed,
	output logic             cableIndicatorGreen,
	output logic             powerIndicatorRed,
	output logic             powerIndicatorGreen,
	// Interrupt.
	output logic             irq,
	// AXI4-Lite write channels.
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// AXI4-Lite read channels.
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);
	typedef struct packed {
		olsi_laser_e laser;
		logic [3:0]  irqStat;
		logic [3:0]  irqEn;
		logic [31:0] tempSecs;
		logic        optPrev;
		logic        cablePrev;
		logic        hotPrev;
		logic        awHave;
		logic        wHave;
		logic [7:0]  wAddr;
		logic [31:0] wData;
		logic        wStrb0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [1:0]  tempLamp;
		logic [1:0]  laserLamp;
		logic [1:0]  optLamp;
		logic [1:0]  errLamp;
		logic [1:0]  cableLamp;
		logic [1:0]  powerLamp;
		logic        txEnable;
		logic        dataEnable;
		logic        irq;
		logic        armed;
	} olsi_main_s;

	localparam olsi_main_s MAIN_RST = '{
		laser: LAS_RUN,
		irqEn: `OLSI_IRQ_EN_RST,
		default: '0
	};

	olsi_main_s state_q;
	olsi_main_s state_d;

	logic       blinkPhase;
	logic       secTick;
	logic [1:0] trafficIn;
	logic [1:0] trafficActive;
	logic       optActive;
	logic       cableActive;
	logic       optLinkOk;
	logic       warnSet;

	function automatic olsi_reg_e olsiRegIdx(input logic [7:0] addr);
		case (addr)
			`OLSI_CTRL_OFF:      return REG_CTRL;
			`OLSI_STATUS_OFF:    return REG_STATUS;
			`OLSI_IRQ_STAT_OFF:  return REG_IRQ_STAT;
			`OLSI_IRQ_EN_OFF:    return REG_IRQ_EN;
			`OLSI_IRQ_CLR_OFF:   return REG_IRQ_CLR;
			`OLSI_TEMP_TIME_OFF: return REG_TEMP_TIME;
			default:             return REG_NONE;
		endcase
	endfunction

	// Returns {red, green}; a flashing lamp is lit only in the bright blink phase.
	function automatic logic [1:0] olsiLamp(input olsi_led_e colour, input logic flash, input logic phase);
		logic lit;
		lit = !flash || phase;
		unique case (colour)
			LED_OFF:    return 2'h0;
			LED_GREEN:  return {1'b0, lit};
			LED_ORANGE: return {lit, lit};
			LED_RED:    return {lit, 1'b0};
		endcase
	endfunction

	olsi_tick_gen #(
		.BLINK_CYCLES(BLINK_CYCLES),
		.SEC_CYCLES  (SEC_CYCLES)
	) u_tick (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.blinkPhase(blinkPhase),
		.secTick   (secTick)
	);

	assign trafficIn = {cableTraffic, optTraffic};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_act
			olsi_act_stretch #(
				.HOLD_CYCLES(STRETCH_CYCLES)
			) u_act (
				.clk_sys (clk_sys),
				.reset_n (reset_n),
				.activity(trafficIn[gi]),
				.active  (trafficActive[gi])
			);
		end
	endgenerate

	assign optActive   = trafficActive[0];
	assign cableActive = trafficActive[1];
	assign optLinkOk   = optLinkUp && state_q.txEnable && !partnerTxOff;
	assign warnSet     = tempOutOfRange || tempBeyondMargin || laserWearOut
		|| (state_q.laser == LAS_TRIP) || !optLinkOk;

	always_comb begin
		logic        doWrite;
		olsi_reg_e   wIdx;
		logic        rearm;
		logic [3:0]  clrMask;
		logic [3:0]  events;
		logic [31:0] rdWord;
		olsi_led_e   colour;
		logic        flash;
		doWrite = 1'b0;
		wIdx    = REG_NONE;
		rearm   = 1'b0;
		clrMask = 4'h0;
		events  = 4'h0;
		rdWord  = 32'h0;
		colour  = LED_OFF;
		flash   = 1'b0;
		state_d = state_q;
		state_d.armed = 1'b1;

		// Write address and data are taken in either order, one write at a time.
		if (awvalid && state_q.awready) begin
			state_d.awHave = 1'b1;
			state_d.wAddr  = awaddr;
		end
		if (wvalid && state_q.wready) begin
			state_d.wHave  = 1'b1;
			state_d.wData  = wdata;
			state_d.wStrb0 = wstrb[0];
		end
		if (state_q.bvalid && bready) begin
			state_d.bvalid = 1'b0;
		end
		doWrite = state_q.awHave && state_q.wHave && !state_q.bvalid;
		wIdx = olsiRegIdx(state_q.wAddr);
		if (doWrite) begin
			state_d.awHave = 1'b0;
			state_d.wHave  = 1'b0;
			state_d.bvalid = 1'b1;
			state_d.bresp  = (wIdx == REG_NONE) ? `OLSI_RESP_SLVERR : `OLSI_RESP_OKAY;
			if (state_q.wStrb0) begin
				unique case (wIdx)
					REG_CTRL:      rearm = state_q.wData[`OLSI_CTRL_REARM];
					REG_IRQ_EN:    state_d.irqEn = state_q.wData[3:0];
					REG_IRQ_CLR:   clrMask = state_q.wData[3:0];
					REG_STATUS, REG_IRQ_STAT, REG_TEMP_TIME, REG_NONE: ;
					default: ;
				endcase
			end
		end
		state_d.awready = !state_d.awHave && !state_d.bvalid;
		state_d.wready  = !state_d.wHave && !state_d.bvalid;

		// Overcurrent trips the transmitter until software rearms it with the fault gone.
		unique case (state_q.laser)
			LAS_RUN: begin
				if (laserOverCurrent) begin
					state_d.laser = LAS_TRIP;
				end
			end
			LAS_TRIP: begin
				if (rearm && !laserOverCurrent) begin
					state_d.laser = LAS_RUN;
				end
			end
		endcase
		state_d.txEnable = (state_d.laser == LAS_RUN);

		// Hot operation only counts time; transmission is left running.
		if (secTick && tempBeyondMargin) begin
			state_d.tempSecs = state_q.tempSecs + 32'h1;
		end

		// Events; a set arriving with a clear of the same bit wins.
		events[`OLSI_EV_LASER_TRIP] = (state_q.laser == LAS_RUN) && laserOverCurrent;
		events[`OLSI_EV_TEMP_HOT]   = tempBeyondMargin && !state_q.hotPrev;
		events[`OLSI_EV_OPT_LOST]   = !optLinkOk && state_q.optPrev;
		events[`OLSI_EV_CABLE_LOST] = !cableLinkUp && state_q.cablePrev;
		state_d.hotPrev   = tempBeyondMargin;
		state_d.optPrev   = optLinkOk;
		state_d.cablePrev = cableLinkUp;
		state_d.irqStat   = (state_q.irqStat & ~clrMask) | events;
		state_d.irq       = |(state_d.irqStat & state_d.irqEn);

		// Reads are answered on the cycle after the address is taken.
		rdWord[`OLSI_ST_TX_EN]      = state_q.txEnable;
		rdWord[`OLSI_ST_OPT_OK]     = optLinkOk;
		rdWord[`OLSI_ST_CABLE_UP]   = cableLinkUp;
		rdWord[`OLSI_ST_TEMP_WARN]  = tempOutOfRange;
		rdWord[`OLSI_ST_TEMP_HOT]   = tempBeyondMargin;
		rdWord[`OLSI_ST_LASER_WEAR] = laserWearOut;
		rdWord[`OLSI_ST_LASER_TRIP] = (state_q.laser == LAS_TRIP);
		rdWord[`OLSI_ST_INIT_DONE]  = initDone;
		if (arvalid && state_q.arready) begin
			state_d.rvalid = 1'b1;
			state_d.rresp  = `OLSI_RESP_OKAY;
			state_d.rdata  = 32'h0;
			unique case (olsiRegIdx(araddr))
				REG_CTRL:      state_d.rdata = {31'h0, state_q.laser == LAS_TRIP};
				REG_STATUS:    state_d.rdata = rdWord;
				REG_IRQ_STAT:  state_d.rdata = {28'h0, state_q.irqStat};
				REG_IRQ_EN:    state_d.rdata = {28'h0, state_q.irqEn};
				REG_IRQ_CLR:   state_d.rdata = 32'h0;
				REG_TEMP_TIME: state_d.rdata = state_q.tempSecs;
				REG_NONE:      state_d.rresp = `OLSI_RESP_SLVERR;
				default:       state_d.rresp = `OLSI_RESP_SLVERR;
			endcase
		end else if (state_q.rvalid && rready) begin
			state_d.rvalid = 1'b0;
		end
		state_d.arready = !state_d.rvalid;

		// Temperature lamp.
		if (tempBeyondMargin) begin
			colour = LED_RED;
		end else if (tempOutOfRange) begin
			colour = LED_ORANGE;
		end else begin
			colour = LED_OFF;
		end
		state_d.tempLamp = olsiLamp(colour, 1'b0, blinkPhase);

		// Laser lamp.
		flash = 1'b0;
		if (state_d.laser == LAS_TRIP) begin
			colour = LED_ORANGE;
			flash  = 1'b1;
		end else if (laserWearOut) begin
			colour = LED_ORANGE;
		end else begin
			colour = LED_OFF;
		end
		state_d.laserLamp = olsiLamp(colour, flash, blinkPhase);

		// Optical link lamp.
		if (!optLinkOk) begin
			colour = LED_OFF;
		end else if (optActive) begin
			colour = LED_ORANGE;
		end else begin
			colour = LED_GREEN;
		end
		state_d.optLamp = olsiLamp(colour, 1'b0, blinkPhase);

		// Link error lamp; a local fault outranks one reported by the partner.
		if (!cableLinkUp || localQualityLow) begin
			colour = LED_RED;
		end else if (remoteCableDown || remoteQualityLow) begin
			colour = LED_ORANGE;
		end else begin
			colour = LED_OFF;
		end
		state_d.errLamp = olsiLamp(colour, 1'b0, blinkPhase);

		// Cable lamp.
		if (!cableLinkUp) begin
			colour = LED_OFF;
		end else if (cableActive) begin
			colour = LED_ORANGE;
		end else begin
			colour = LED_GREEN;
		end
		state_d.cableLamp = olsiLamp(colour, 1'b0, blinkPhase);

		// Power lamp; initialisation is shown before warnings since the link is still down then.
		flash = 1'b1;
		if (deviceError) begin
			colour = LED_RED;
			flash  = 1'b0;
		end else if (!initDone) begin
			colour = LED_GREEN;
		end else if (warnSet) begin
			colour = LED_RED;
		end else begin
			colour = LED_GREEN;
			flash  = 1'b0;
		end
		state_d.powerLamp = olsiLamp(colour, flash, blinkPhase);

		// Data moves only over a live optical path on a healthy, initialised device.
		state_d.dataEnable = optLinkOk && initDone && !deviceError;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_q <= MAIN_RST;
		end else begin
			state_q <= state_d;
		end
	end

	assign txEnable                  = state_q.txEnable;
	assign dataEnable                = state_q.dataEnable;
	assign temperatureIndicatorRed   = state_q.tempLamp[1];
	assign temperatureIndicatorGreen = state_q.tempLamp[0];
	assign laserIndicatorRed         = state_q.laserLamp[1];
	assign laserIndicatorGreen       = state_q.laserLamp[0];
	assign opticalLinkIndicatorRed   = state_q.optLamp[1];
	assign opticalLinkIndicatorGreen = state_q.optLamp[0];
	assign linkErrorIndicatorRed     = state_q.errLamp[1];
	assign linkErrorIndicatorGreen   = state_q.errLamp[0];
	assign cableIndicatorRed         = state_q.cableLamp[1];
	assign cableIndicatorGreen       = state_q.cableLamp[0];
	assign powerIndicatorRed         = state_q.powerLamp[1];
	assign powerIndicatorGreen       = state_q.powerLamp[0];
	assign irq                       = state_q.irq;
	assign awready                   = state_q.awready;
	assign wready                    = state_q.wready;
	assign bvalid                    = state_q.bvalid;
	assign bresp                     = state_q.bresp;
	assign arready                   = state_q.arready;
	assign rvalid                    = state_q.rvalid;
	assign rdata                     = state_q.rdata;
	assign rresp                     = state_q.rresp;

	default clocking cb @(posedge clk_sys);
	endclocking
	// Checks start one cycle after reset so the reset image of the lamps is never judged against live inputs.
	default disable iff (!reset_n || !state_q.armed);

	sequence s_trip_event;
		(state_q.laser == LAS_RUN) && laserOverCurrent;
	endsequence
	sequence s_trip_shown;
		!txEnable && (laserIndicatorRed == laserIndicatorGreen);
	endsequence
	sequence s_cable_burst;
		(cableTraffic && cableLinkUp) ##1 cableLinkUp;
	endsequence

	a_temp_dark: assert property (!tempOutOfRange && !tempBeyondMargin
		|=> !temperatureIndicatorRed && !temperatureIndicatorGreen) else $error("temperature lamp lit in range");
	a_temp_warn: assert property (tempOutOfRange && !tempBeyondMargin
		|=> temperatureIndicatorRed && temperatureIndicatorGreen) else $error("temperature lamp not orange");
	a_temp_hot: assert property (tempBeyondMargin
		|=> temperatureIndicatorRed && !temperatureIndicatorGreen) else $error("temperature lamp not red");
	a_temp_timer: assert property (tempBeyondMargin && secTick
		|=> state_q.tempSecs == $past(state_q.tempSecs) + 32'h1) else $error("hot time not counted");
	a_laser_dark: assert property (!laserOverCurrent && state_q.laser == LAS_RUN
		&& !laserWearOut |=> !laserIndicatorRed && !laserIndicatorGreen) else $error("laser lamp lit");
	a_laser_wear: assert property (state_q.laser == LAS_RUN && !laserOverCurrent && laserWearOut
		|=> laserIndicatorRed && laserIndicatorGreen && txEnable) else $error("laser wear not orange");
	a_laser_trip: assert property (s_trip_event |=> s_trip_shown) else $error("overcurrent not tripped");
	a_power_err: assert property (deviceError
		|=> powerIndicatorRed && !powerIndicatorGreen && !dataEnable) else $error("device error not shown");
	a_optic_dark: assert property (!optLinkUp || partnerTxOff || !txEnable
		|=> !opticalLinkIndicatorRed && !opticalLinkIndicatorGreen && !dataEnable) else $error("optic lamp lit");
	a_optic_idle: assert property (optLinkOk && !optActive
		|=> opticalLinkIndicatorGreen && !opticalLinkIndicatorRed) else $error("optic lamp not green");
	a_optic_busy: assert property (optLinkOk && optActive
		|=> opticalLinkIndicatorGreen && opticalLinkIndicatorRed) else $error("optic lamp not orange");
	a_err_remote: assert property (cableLinkUp && !localQualityLow && (remoteCableDown || remoteQualityLow)
		|=> linkErrorIndicatorRed && linkErrorIndicatorGreen) else $error("remote fault not orange");
	a_err_local: assert property (!cableLinkUp || localQualityLow
		|=> linkErrorIndicatorRed && !linkErrorIndicatorGreen) else $error("local fault not red");
	a_cable_dark: assert property (!cableLinkUp
		|=> !cableIndicatorRed && !cableIndicatorGreen) else $error("cable lamp lit");
	a_cable_idle: assert property (cableLinkUp && !cableActive
		|=> cableIndicatorGreen && !cableIndicatorRed) else $error("cable lamp not green");
	a_cable_burst: assert property (s_cable_burst |=> cableIndicatorRed && cableIndicatorGreen)
		else $error("cable traffic not shown");
	a_power_ready: assert property (initDone && !deviceError && !warnSet
		|=> powerIndicatorGreen && !powerIndicatorRed) else $error("power lamp not steady green");
	a_power_flash: assert property (!deviceError && !initDone
		|=> !powerIndicatorRed && (powerIndicatorGreen == $past(blinkPhase))) else $error("init flash wrong");
	a_irq_level: assert property (irq == |(state_q.irqStat & state_q.irqEn)) else $error("irq level wrong");
	a_wr_answer: assert property (state_q.awHave && state_q.wHave && !state_q.bvalid |=> bvalid && !awready)
		else $error("write not answered");
	a_rd_answer: assert property (arvalid && arready |=> rvalid && !arready) else $error("read not answered");
endmodule

// ---- verif/olsi_panel_model.sv ----
module olsi_panel_model
	import olsi_pkg::*;
(
	// Lamp drives from the block.
	input  wire logic [5:0] red,
	input  wire logic [5:0] green,
	// Colour an operator sees on each lamp.
	output olsi_led_e       colour [6]
);
	timeunit 1ns;
	timeprecision 1ns;

	// Red and green lit together read as orange.
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			colour[i] = olsi_led_e'({red[i], red[i] ^ green[i]});
		end
	end
endmodule

// ---- verif/optical_link_status_indicator_tb.sv ----
module optical_link_status_indicator_tb
	import olsi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, reset_n, txEnable, dataEnable, irq, look = 0;
	logic [13:0] mon;
	logic [5:0] red, green;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp;
	olsi_led_e c [6];
	olsi_led_e eT, eE, eP;
	logic [29:0] q[$];
	logic [29:0] ent;
	int errors = 0, total_checks = 0, cycles = 0, seed = 11297;
	logic [31:0] r;
	logic ok, l0;

	olsi_indicator_top #(.BLINK_CYCLES(4), .SEC_CYCLES(16), .STRETCH_CYCLES(8)) dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .tempOutOfRange(mon[0]), .tempBeyondMargin(mon[1]),
		.laserWearOut(mon[2]), .laserOverCurrent(mon[3]), .optLinkUp(mon[4]), .partnerTxOff(mon[5]),
		.optTraffic(mon[6]), .localQualityLow(mon[7]), .remoteQualityLow(mon[8]), .remoteCableDown(mon[9]),
		.cableLinkUp(mon[10]), .cableTraffic(mon[11]), .initDone(mon[12]), .deviceError(mon[13]),
		.txEnable(txEnable), .dataEnable(dataEnable), .irq(irq),
		.temperatureIndicatorRed(red[0]), .temperatureIndicatorGreen(green[0]),
		.laserIndicatorRed(red[1]), .laserIndicatorGreen(green[1]),
		.opticalLinkIndicatorRed(red[2]), .opticalLinkIndicatorGreen(green[2]),
		.linkErrorIndicatorRed(red[3]), .linkErrorIndicatorGreen(green[3]),
		.cableIndicatorRed(red[4]), .cableIndicatorGreen(green[4]),
		.powerIndicatorRed(red[5]), .powerIndicatorGreen(green[5]),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));

	olsi_panel_model panel (.red(red), .green(green), .colour(c));

	initial begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic test_done();
		if (errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Expected value in the low half, compare mask in the high half.
	task automatic expect_now(input logic [14:0] e, input logic [14:0] m);
		q.push_back({m, e});
		look <= 1;
		@(posedge clk_sys);
		look <= 0;
	endtask

	always @(posedge clk_sys) begin
		if (look) begin
			ent = q.pop_front();
			check("lamps", {c[5], c[4], c[3], c[2], c[1], c[0], txEnable, dataEnable, irq} & ent[29:15],
				ent[14:0] & ent[29:15]);
		end
		cycles++;
		if (cycles == 3000) begin
			errors++;
			test_done();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		bready <= 0;
	endtask

	task automatic rdr(input logic [7:0] a, input logic [1:0] eResp, input logic [31:0] eData);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		check("rresp", rresp, eResp);
		check("rdata", rdata, eData);
		rready <= 0;
	endtask

	initial begin
		reset_n = 0;
		mon = 14'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1;
		rdr(8'h0c, 2'h0, 32'h0);
		rdr(8'h18, 2'h2, 32'h0);
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			mon <= {r[9] & r[10], 1'b1, 1'b0, r[8], r[7], r[6], r[5], 1'b0, r[4], r[3], 1'b0, r[2], r[1] & r[0], r[0]};
			repeat (3) @(posedge clk_sys);
			ok = r[3] & !r[4];
			eT = (r[1] & r[0]) ? LED_RED : r[0] ? LED_ORANGE : LED_OFF;
			eE = (r[5] | !r[8]) ? LED_RED : (r[6] | r[7]) ? LED_ORANGE : LED_OFF;
			eP = (r[9] & r[10]) ? LED_RED : LED_GREEN;
			expect_now({eP, r[8] ? LED_GREEN : LED_OFF, eE, ok ? LED_GREEN : LED_OFF,
				r[2] ? LED_ORANGE : LED_OFF, eT, 1'b1, ok & !(r[9] & r[10]), 1'b0},
				{{2{(r[9] & r[10]) | !(r[0] | r[2] | !ok)}}, 13'h1fff});
		end
		mon <= 14'h1c10 | 14'h0840;
		@(posedge clk_sys);
		mon <= 14'h1410;
		repeat (2) @(posedge clk_sys);
		expect_now({LED_GREEN, LED_ORANGE, LED_OFF, LED_ORANGE, LED_OFF, LED_OFF, 3'h6}, 15'h7fff);
		repeat (10) @(posedge clk_sys);
		expect_now({LED_GREEN, LED_GREEN, LED_OFF, LED_GREEN, LED_OFF, LED_OFF, 3'h6}, 15'h7fff);
		wr(8'h0c, 32'h1);
		mon <= 14'h1418;
		repeat (3) @(posedge clk_sys);
		expect_now({LED_OFF, LED_GREEN, LED_OFF, LED_OFF, LED_OFF, LED_OFF, 3'h1}, 15'h1f9f);
		l0 = red[1];
		check("flash", {red[1], green[1]}, {l0, l0});
		repeat (4) @(posedge clk_sys);
		check("flash", {red[1], green[1]}, {!l0, !l0});
		mon <= 14'h1410;
		wr(8'h10, 32'h1);
		wr(8'h00, 32'h1);
		repeat (3) @(posedge clk_sys);
		expect_now({12'h0, 3'h6}, 15'h0007);
		test_done();
	end
endmodule
